// *** src/bscc_chain.v ***
// Boundary-scan cell chain, cells 1..55: display data and keypad scan pads.
// Test clock, serial input, TAP state strobes and test reset arrive from pins and
// are synchronised to clk; instruction code comes from the controller as pins too.
`timescale 1ns/10ps
`include "bscc_defs.vh"
module bscc_chain #(
   parameter PADS = `BSCC_PADS
) (
   input  wire              clk,
   input  wire              rst,
   input  wire              testClock,
   input  wire              testReset_n,
   input  wire              testDataIn,
   input  wire [3:0]        instruction,
   input  wire              captureDr,
   input  wire              shiftDr,
   input  wire              updateDr,
   input  wire [PADS-1:0]   padIn,
   input  wire [PADS:0]     coreOut,
   input  wire [PADS-1:0]   coreOutEn,
   output reg               testDataOut,
   output reg               testDataOutEn,
   output reg  [PADS-1:0]   coreIn,
   output reg  [PADS:0]     padOut,
   output reg  [PADS-1:0]   padOutEn
);
   // Lone display output, then an IN,OUT,EN triple for every pad
   localparam N    = 3 * PADS + 1;
   localparam LONE = `BSCC_CELL_LONE_OUT;

   // Instructions that put the chain between serial input and output
   function chainIns;
      input [3:0] code;
      begin
         chainIns = (code == `BSCC_INS_SAMPLE) |
                    (code == `BSCC_INS_EXTEST) |
                    (code == `BSCC_INS_INTEST);
      end
   endfunction

   // Instructions under which the hold stage drives pads and core
   function holdsPads;
      input [3:0] code;
      begin
         holdsPads = (code == `BSCC_INS_EXTEST) |
                     (code == `BSCC_INS_INTEST) |
                     (code == `BSCC_INS_CLAMP)  |
                     (code == `BSCC_INS_CLAMP_WITH_OUTPUTS_DISABLED);
      end
   endfunction

   // Instructions that force every three-state pad driver off; the lone display output stays driven
   function padsOff;
      input [3:0] code;
      begin
         padsOff = (code == `BSCC_INS_HIGHZ) |
                   (code == `BSCC_INS_CLAMP_WITH_OUTPUTS_DISABLED);
      end
   endfunction

   // Stage one of each synchroniser; read only by stage two
   reg             tckMeta;
   reg             tdiMeta;
   reg             capMeta;
   reg             sftMeta;
   reg             updMeta;
   reg             trnMeta;
   reg  [3:0]      insMeta;
   reg  [PADS-1:0] padMeta;
   // Stage two: the only copies that logic reads
   reg             tckSync;
   reg             tdiSync;
   reg             capSync;
   reg             sftSync;
   reg             updSync;
   reg             trnSync;
   reg  [3:0]      insSync;
   reg  [PADS-1:0] padSync;
   reg             tckPrev;
   // Chain storage: shift stage and parallel hold stage
   reg  [N:1]      shiftReg;
   reg  [N:1]      holdReg;
   reg  [N:1]      next_shiftReg;
   wire [N:1]      capValue;
   wire [PADS:0]   next_padOut;
   wire [PADS-1:0] next_coreIn;
   wire [PADS-1:0] next_padOutEn;
   wire            rise;
   wire            fall;
   wire            testReset;
   wire            inChain;
   wire            testMode;
   wire            allOff;
   wire            inTest;

   // Control pins and serial data share one latency, so they stay aligned
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         tckMeta <= 1'b0;
         tdiMeta <= 1'b0;
         capMeta <= 1'b0;
         sftMeta <= 1'b0;
         updMeta <= 1'b0;
         trnMeta <= 1'b0;
         tckSync <= 1'b0;
         tdiSync <= 1'b0;
         capSync <= 1'b0;
         sftSync <= 1'b0;
         updSync <= 1'b0;
         trnSync <= 1'b0;
      end else begin
         tckMeta <= testClock;
         tdiMeta <= testDataIn;
         capMeta <= captureDr;
         sftMeta <= shiftDr;
         updMeta <= updateDr;
         trnMeta <= testReset_n;
         tckSync <= tckMeta;
         tdiSync <= tdiMeta;
         capSync <= capMeta;
         sftSync <= sftMeta;
         updSync <= updMeta;
         trnSync <= trnMeta;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         insMeta <= `BSCC_INS_RESET;
         insSync <= `BSCC_INS_RESET;
      end else begin
         insMeta <= instruction;
         insSync <= insMeta;
      end
   end

   // Pad levels come from outside the clock domain
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         padMeta <= {PADS{1'b0}};
         padSync <= {PADS{1'b0}};
      end else begin
         padMeta <= padIn;
         padSync <= padMeta;
      end
   end

   // Previous level starts low like the idle test clock: no false edge
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         tckPrev <= 1'b0;
      end else begin
         tckPrev <= tckSync;
      end
   end

   assign rise      = tckSync & ~tckPrev;
   assign fall      = ~tckSync & tckPrev;
   assign testReset = ~trnSync;
   assign inChain   = chainIns(insSync);
   assign testMode  = holdsPads(insSync);
   assign allOff    = padsOff(insSync);
   assign inTest    = (insSync == `BSCC_INS_INTEST);

   // Shift has priority over capture if the controller drives both
   always @* begin
      next_shiftReg = shiftReg;
      if (sftSync) begin
         next_shiftReg = {shiftReg[N-1:1], tdiSync};
      end else if (capSync) begin
         next_shiftReg = capValue;
      end
   end

   // Cleared on test reset only for determinism
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         shiftReg <= {N{1'b0}};
      end else if (testReset) begin
         shiftReg <= {N{1'b0}};
      end else if (rise && inChain) begin
         shiftReg <= next_shiftReg;
      end
   end

   // Clamp codes are not chain codes, so held values change only on rst or test reset
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         holdReg <= {N{1'b0}};
      end else if (testReset) begin
         holdReg <= {N{1'b0}};
      end else if (rise && inChain && updSync && !sftSync && !capSync) begin
         holdReg <= shiftReg;
      end
   end

   // One cell per pin or group enable
   assign capValue[LONE]    = coreOut[PADS];
   assign next_padOut[PADS] = testMode ? holdReg[LONE] : coreOut[PADS];

   genvar g;
   generate
      for (g = 0; g < PADS; g = g + 1) begin : padCells
         localparam IN_CELL  = 3 * g + `BSCC_CELL_FIRST_TRIPLE;
         localparam OUT_CELL = IN_CELL + 1;
         localparam EN_CELL  = IN_CELL + 2;
         assign capValue[IN_CELL]  = inTest ? ~coreIn[g] : padSync[g];
         assign capValue[OUT_CELL] = coreOut[g];
         assign capValue[EN_CELL]  = coreOutEn[g];
         assign next_coreIn[g]     = testMode ? holdReg[IN_CELL] : padSync[g];
         assign next_padOut[g]     = testMode ? holdReg[OUT_CELL] : coreOut[g];
         assign next_padOutEn[g]   = allOff ? 1'b0 :
                                     (testMode ? holdReg[EN_CELL] : coreOutEn[g]);
      end
   endgenerate

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         coreIn   <= {PADS{1'b0}};
         padOut   <= {(PADS+1){1'b0}};
         padOutEn <= {PADS{1'b0}};
      end else begin
         coreIn   <= next_coreIn;
         padOut   <= next_padOut;
         padOutEn <= next_padOutEn;
      end
   end

   // Last cell shown on the falling edge, so it is stable at the next rise
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         testDataOut   <= 1'b0;
         testDataOutEn <= 1'b0;
      end else if (fall) begin
         testDataOut   <= shiftReg[N];
         testDataOutEn <= sftSync & inChain;
      end
   end
endmodule // bscc_chain

// *** common/bscc_defs.vh ***
// Constants for the boundary-scan cell chain: cell kinds, chain map, instruction codes.
// Assumes a test controller outside that decodes the instruction and walks the TAP states.
// How it works
// - Cell 1 sits next to serial input; bits shift toward serial output.
// - Every covered output pad except the lone display output (cell 1) is three-state, enable overridable by a scan cell.
// - Each input cell can feed a test value to core instead of pin.
// - Each cell tied to one pin or one group enable, per chain map.
// - Chain is in the scan path only for preload, external and internal test.
// - Chain contents undefined after power-up; test reset need not preserve them.
// - Internal-test capture takes complemented input cells, true core outputs.
`ifndef BSCC_DEFS_VH
`define BSCC_DEFS_VH
// Visible cells plus the enable cell that closes the last keypad-in pad
`define BSCC_CELLS      55
`define BSCC_PADS       18
`define BSCC_CELL_LONE_OUT 1
// Instruction codes as presented by the controller
`define BSCC_INS_EXTEST 4'h0
`define BSCC_INS_SAMPLE 4'h3
`define BSCC_INS_CLAMP  4'h5
`define BSCC_INS_HIGHZ  4'h7
`define BSCC_INS_CLAMP_WITH_OUTPUTS_DISABLED 4'h9
`define BSCC_INS_INTEST 4'hC
// Code held while in reset: none of the above, so pads follow the core
`define BSCC_INS_RESET  4'hF
// Cell 1 is a lone output (display bit 4); then IN,OUT,EN triples per pad
`define BSCC_CELL_FIRST_TRIPLE 2
`endif

// *** testbench/bscc_chain_properties.sv ***
// Port checker for the scan chain: modes, serial enable, hold.
// Assumes a bind onto bscc_chain; one clk domain, rst high.
`timescale 1ns/10ps
module bscc_chain_properties (
   input wire        clk,
   input wire        rst,
   input wire        testClock,
   input wire        shiftDr,
   input wire        updateDr,
   input wire        testDataOut,
   input wire        testDataOutEn,
   input wire [3:0]  instruction,
   input wire [18:0] coreOut,
   input wire [18:0] padOut,
   input wire [17:0] padOutEn
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_sh; shiftDr && instruction == 4'h3; endsequence
   a_oe_on: assert property (s_sh [*8] ##1 s_sh [*4] |-> testDataOutEn) else $error("oe");
   a_oe_off: assert property (!shiftDr [*8] ##1 !shiftDr [*4] |-> !testDataOutEn) else $error("oe");
   a_tdo_fall: assert property ($changed(testDataOut) |-> $past(!testClock, 2)) else $error("tdo");
   a_hz_off: assert property (instruction == 4'h7 [*5] |-> padOutEn == 0) else $error("hz");
   a_cz_off: assert property (instruction == 4'h9 [*5] |-> padOutEn == 0) else $error("cz");
   a_clamp_hold: assert property (instruction == 4'h5 [*5] |=> $stable(padOut)) else $error("cl");
   a_ext_hold: assert property ((instruction == 4'h0 && !updateDr) [*8] |=> $stable(padOut))
      else $error("ex");
   a_norm_pass: assert property ((instruction == 4'hF && $stable(coreOut)) [*5] |-> padOut == coreOut)
      else $error("nm");
endmodule // bscc_chain_properties
bind bscc_chain bscc_chain_properties p_i (.*);

// *** testbench/bscc_ctrl.sv ***
// Test controller model: test clock, serial data, TAP levels, instruction.
// Assumes the bench calls tick; test clock stands still between calls.
`timescale 1ns/10ps
module bscc_ctrl (
   output reg       tck = 1'h0,
   output reg       tdi = 1'h0,
   input  wire      tdo,
   output reg [2:0] st = 3'h0,
   output reg [3:0] ins = 4'hF
);
   task tick(input b, output v);
      begin
         tdi = b;
         #100 v = tdo;
         tck = 1;
         #400 tck = 0;
         #300;
      end
   endtask
endmodule // bscc_ctrl

// *** testbench/bscc_chain_test.sv ***
// Bench: preload with serial round trip, then extest, clamp, high-z, normal, intest capture.
// Assumes bscc_ctrl plays the controller; checker bound in its own file.
`timescale 1ns/10ps
module bscc_chain_test;
   reg         clk = 0, rst = 1, trn = 0, o;
   reg  [55:1] p = 55'h7BEFBEFBEFBEFA; // Guard values, cell 1 at bit 1
   reg  [55:1] x;
   localparam [18:0] coreOutVal = 19'h3C3C3;
   localparam [17:0] coreEnVal  = 18'h0F0F0;
   localparam [17:0] padInVal   = 18'h15A5A;
   wire        tck, tdi, tdo;
   wire [2:0]  st;
   wire [3:0]  ins;
   wire [17:0] coreIn, pe;
   wire [18:0] po;
   integer     n_errors = 0, total_checks = 0, j;
   always #50 clk = ~clk;
   bscc_ctrl ctl_i (.tck(tck), .tdi(tdi), .tdo(tdo), .st(st), .ins(ins));
   bscc_chain bscc_chain_i (.clk(clk), .rst(rst), .testClock(tck), .testReset_n(trn),
      .testDataIn(tdi), .instruction(ins), .captureDr(st[2]), .shiftDr(st[1]), .updateDr(st[0]),
      .padIn(padInVal), .coreOut(coreOutVal), .coreOutEn(coreEnVal), .testDataOut(tdo),
      .testDataOutEn(), .coreIn(coreIn), .padOut(po), .padOutEn(pe));
   task chk(input [47:0] nm, input [18:0] e, s);
      begin
         total_checks = total_checks + 1;
         if (e !== s) begin n_errors = n_errors + 1; $display("mismatch %0s %h %h", nm, e, s); end
      end
   endtask
   task preload_extest;
      begin
         {ctl_i.ins, ctl_i.st} = 7'h1A;
         for (j = 0; j < 110; j = j + 1) begin
            ctl_i.tick(p[55 - j % 55], o);
            if (j > 54) chk("serial", p[55 - j % 55], o);
         end
         ctl_i.st = 3'h1;
         ctl_i.tick(1'b0, o);
         {ctl_i.ins, ctl_i.st} = 7'h00;
         #1600 chk("pads", 19'h2AAAA, po);
         chk("oe", 19'h3FFFF, pe);
         chk("core", 19'h3FFFF, coreIn);
      end
   endtask
   task modes;
      begin
         {ctl_i.ins, ctl_i.st} = 7'h2B;
         ctl_i.tick(1'b1, o);
         {ctl_i.ins, ctl_i.st} = 7'h28;
         #800 chk("clamp", 19'h2AAAA, po);
         ctl_i.ins = 4'h9;
         #800 chk("clamp_with_outputs_disabled", 0, pe);
         ctl_i.ins = 4'h7;
         #800 chk("highz", 0, pe);
         ctl_i.ins = 4'hF;
         #800 chk("normal", coreOutVal, po);
         chk("corein", padInVal, coreIn);
      end
   endtask
   task intest_capture;
      begin
         x[1] = coreOutVal[18];
         for (j = 0; j < 18; j = j + 1) begin
            x[3 * j + 2] = ~p[3 * j + 2];
            x[3 * j + 3] = coreOutVal[j];
            x[3 * j + 4] = coreEnVal[j];
         end
         {ctl_i.ins, ctl_i.st} = 7'h64;
         ctl_i.tick(1'b0, o);
         ctl_i.st = 3'h2;
         for (j = 55; j > 0; j = j - 1) begin
            ctl_i.tick(1'b0, o);
            chk("intest", x[j], o);
         end
         {ctl_i.ins, ctl_i.st} = 7'h78;
         ctl_i.tick(1'b0, o);
      end
   endtask
   task end_of_test;
      begin
         $display("errors %0d checks %0d", n_errors, total_checks);
         if (n_errors == 0 && total_checks > 0) $display("verification passed");
         else $display("verification failed");
         $finish;
      end
   endtask
   initial begin
      #551 rst = 0;
      trn = 1;
      #400 preload_extest;
      modes;
      intest_capture;
      end_of_test;
   end
   initial begin
      #400000 n_errors = n_errors + 1;
      end_of_test;
   end
endmodule // bscc_chain_test
